//--- rtl/irh_consts.svh
// Constants for the register read command handler and its controller.
// Assumes inclusion by bare name from the device end, controller end, checker and bench files.
`ifndef IRH_CONSTS_SVH
`define IRH_CONSTS_SVH
// Bus addresses and subaddresses on the link
`define IRH_DEV_W 8'h3a
`define IRH_DEV_R 8'h3b
`define IRH_SUB_WR 8'h68
`define IRH_SUB_RD 8'h69
// Command codes
`define IRH_CODE_REG_RD 4'hd
`define IRH_CODE_REG_WR 4'h9
`define IRH_CODE_MEM0 4'he
`define IRH_CODE_MEM1 4'hf
// Register space and converter setup register
`define IRH_REG_AW 8
`define IRH_REG_SETUP 8'h8e
`define IRH_SETUP_RST 20'h08000
`define IRH_FRQ_LSB 10
`define IRH_RANGE_BIT 8
`define IRH_VOLT_LSB 14
`define IRH_VOLT_BIT 9
// Memory areas
`define IRH_MEM_AW 11
`define IRH_STATUS_ADDR 11'h7ee
// Controller APB map
`define IRH_H_CTRL 8'h00
`define IRH_H_ARG 8'h04
`define IRH_H_CNT 8'h08
`define IRH_H_WDATA 8'h0c
`define IRH_H_RDATA 8'h10
`define IRH_H_STATUS 8'h14
`define IRH_GO_BIT 3
`define IRH_AREA_BIT 2
`endif

//--- rtl/irh_device_end.sv
// Device end: decodes register and memory read commands from the link.
// Assumes the controller issues one link op at a time; every op is taken
// and answered on the next clock edge.
//
// Function
// - 256 registers, 8-bit number in two nibbles
// - One register per command, no register blocks
// - Controller sends code d, number, zero nibble
// - Controller writes read subaddress, restarts, reads four
// - Twenty bits returned in low of four bytes
// - Code e reads first area, f second
// - Memory command: code, zero, count, address
// - One word per count; last byte not acknowledged
// - Default read returns low status sixteen bits
// - Registers writable over link; readable except setup register, which reads zero
// - Controller writes only listed register numbers; the controller end sends any arg[7:0] without a check
// - Frequency step bits 13:10, range bit 8
// - Voltage code from bits 16:14 and 9
// - Every read starts with read subaddress, restart
`timescale 1ns/1ps
`include "irh_consts.svh"
module irh_device_end import irh_pkg::*; (
   irh_link_if.dev link,
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_we,
   input wire logic mem_area,
   input wire logic [`IRH_MEM_AW-1:0] mem_addr,
   input wire logic [19:0] mem_wdata,
   output logic [3:0] freq_step,
   output logic freq_range,
   output logic [3:0] volt_code,
   output logic read_pending
);
   // ----------------------------------------------------------------
   // State and storage
   // ----------------------------------------------------------------
   irh_dev_s_t s;
   irh_dev_s_t n;
   logic reg_we;
   logic [`IRH_REG_AW-1:0] reg_wa;
   logic [19:0] reg_wd;
   logic [19:0] reg_q;
   logic [19:0] m0_q;
   logic [19:0] m1_q;
   logic [`IRH_MEM_AW-1:0] m1_ra;
   logic [19:0] cur;
   logic [7:0] rbyte;
   logic wend;
   logic exhausted;

   // Register space, written only by link write commands
   irh_word_ram #(.AW(`IRH_REG_AW)) u_regs (
      .pclk(pclk),
      .we(reg_we),
      .wa(reg_wa),
      .wd(reg_wd),
      .ra(s.addr[`IRH_REG_AW-1:0]),
      .rd(reg_q)
   );

   // First memory area, loaded from the user side
   irh_word_ram #(.AW(`IRH_MEM_AW)) u_mem0 (
      .pclk(pclk),
      .we(mem_we & ~mem_area),
      .wa(mem_addr),
      .wd(mem_wdata),
      .ra(s.addr[`IRH_MEM_AW-1:0]),
      .rd(m0_q)
   );

   // Second memory area; the status cell lives here
   irh_word_ram #(.AW(`IRH_MEM_AW)) u_mem1 (
      .pclk(pclk),
      .we(mem_we & mem_area),
      .wa(mem_addr),
      .wd(mem_wdata),
      .ra(m1_ra),
      .rd(m1_q)
   );

   // Default read looks at the status cell instead of the pointer
   assign m1_ra = (s.pend == P_NONE) ? `IRH_STATUS_ADDR : s.addr[`IRH_MEM_AW-1:0];

   // ----------------------------------------------------------------
   // Word source and byte selection
   // ----------------------------------------------------------------
   // Pick the word being returned; the setup register is write only
   always_comb begin
      case (s.pend)
         P_REG: begin
            cur = (s.addr[7:0] == `IRH_REG_SETUP) ? 20'h00000 : reg_q;
         end
         P_MEM0: begin
            cur = m0_q;
         end
         default: begin
            cur = m1_q;
         end
      endcase
   end

   // Past the requested count a memory read returns zero
   assign exhausted = ((s.pend == P_MEM0) || (s.pend == P_MEM1)) && (s.cnt == 16'h0000);
   // Default read words are two bytes, all others four
   assign wend = (s.pend == P_NONE) ? (s.bi == 2'd1) : (s.bi == 2'd3);

   // Byte of the current word, most significant first
   always_comb begin
      rbyte = 8'h00;
      if (s.pend == P_NONE) begin
         rbyte = s.bi[0] ? cur[7:0] : cur[15:8];
      end else if (!exhausted) begin
         case (s.bi)
            2'd0: begin
               rbyte = 8'h00;
            end
            2'd1: begin
               rbyte = {4'h0, cur[19:16]};
            end
            2'd2: begin
               rbyte = cur[15:8];
            end
            default: begin
               rbyte = cur[7:0];
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Link op decoder
   // ----------------------------------------------------------------
   always_comb begin
      n = s;
      n.ans_v = 1'b0;
      reg_we = 1'b0;
      reg_wa = s.cb[27:20];
      reg_wd = s.cb[19:0];
      if (link.op_valid) begin
         n.ans_v = 1'b1;
         n.ans_a = 1'b0;
         n.ans_b = 8'h00;
         case (link.op_kind)
            OP_START: begin
               // A repeated start keeps any pending read command
               n.st = DS_ADDR;
            end
            OP_STOP: begin
               if (s.st == DS_CMD) begin
                  // Commands act only once the frame closes, so a cut-off
                  // command never half-executes
                  if (s.nb == 4'd2 && s.cb[15:12] == `IRH_CODE_REG_RD) begin
                     n.pend = P_REG;
                     n.addr = {8'h00, s.cb[11:4]};
                     n.cnt = 16'h0001;
                  end else if (s.nb == 4'd4 && s.cb[31:28] == `IRH_CODE_REG_WR) begin
                     reg_we = 1'b1;
                     if (s.cb[27:20] == `IRH_REG_SETUP) begin
                        n.setup = s.cb[19:0];
                     end
                  end else if (s.nb == 4'd6 && s.cb[47:44] == `IRH_CODE_MEM0) begin
                     n.pend = P_MEM0;
                     n.cnt = s.cb[31:16];
                     n.addr = s.cb[15:0];
                  end else if (s.nb == 4'd6 && s.cb[47:44] == `IRH_CODE_MEM1) begin
                     n.pend = P_MEM1;
                     n.cnt = s.cb[31:16];
                     n.addr = s.cb[15:0];
                  end
               end else if (s.st == DS_READ || s.st == DS_SKIP) begin
                  // A finished read frame consumes the command
                  if (s.st == DS_READ || s.bi != 2'd0) begin
                     n.pend = P_NONE;
                  end
               end
               n.st = DS_IDLE;
            end
            OP_WRITE: begin
               case (s.st)
                  DS_ADDR: begin
                     if (link.op_byte == `IRH_DEV_W) begin
                        n.ans_a = 1'b1;
                        n.st = DS_SUB;
                     end else if (link.op_byte == `IRH_DEV_R) begin
                        n.ans_a = 1'b1;
                        n.bi = 2'd0;
                        n.st = DS_READ;
                     end else begin
                        n.st = DS_SKIP;
                     end
                  end
                  DS_SUB: begin
                     if (link.op_byte == `IRH_SUB_WR) begin
                        n.ans_a = 1'b1;
                        n.nb = 4'd0;
                        n.cb = 64'h0;
                        n.st = DS_CMD;
                     end else if (link.op_byte == `IRH_SUB_RD) begin
                        n.ans_a = 1'b1;
                        n.st = DS_IDLE;
                     end else begin
                        n.st = DS_SKIP;
                     end
                  end
                  DS_CMD: begin
                     // Bytes beyond the eighth are refused
                     if (s.nb != 4'd8) begin
                        n.ans_a = 1'b1;
                        n.cb = {s.cb[55:0], link.op_byte};
                        n.nb = s.nb + 4'd1;
                     end
                  end
                  default: begin
                     n.ans_a = 1'b0;
                  end
               endcase
            end
            default: begin
               // Read op: only answered with data inside a read frame
               if (s.st == DS_READ) begin
                  n.ans_a = 1'b1;
                  n.ans_b = rbyte;
                  n.bi = s.bi + 2'd1;
                  if (wend) begin
                     n.bi = 2'd0;
                     if (s.pend != P_NONE && !exhausted) begin
                        n.addr = s.addr + 16'h0001;
                        n.cnt = s.cnt - 16'h0001;
                     end
                  end
                  if (!link.op_mack) begin
                     n.st = DS_SKIP;
                     n.bi = 2'd1;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.st <= DS_IDLE;
         s.pend <= P_NONE;
         s.setup <= `IRH_SETUP_RST;
      end else begin
         s <= n;
      end
   end

   // Converter controls straight from the setup register
   assign freq_step = s.setup[`IRH_FRQ_LSB+3:`IRH_FRQ_LSB];
   assign freq_range = s.setup[`IRH_RANGE_BIT];
   assign volt_code = {s.setup[`IRH_VOLT_LSB+2:`IRH_VOLT_LSB], s.setup[`IRH_VOLT_BIT]};
   assign read_pending = (s.pend != P_NONE);
   assign link.ans_valid = s.ans_v;
   assign link.ans_ack = s.ans_a;
   assign link.ans_byte = s.ans_b;
endmodule

//--- rtl/irh_host_end.sv
// Controller end: takes orders over APB and runs link frames.
// Assumes the device answers every op; waits with no timeout.
`timescale 1ns/1ps
`include "irh_consts.svh"
module irh_host_end import irh_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   irh_link_if.host link
);
   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   irh_host_s_t s;
   irh_host_s_t n;
   logic acc;
   logic mapped;
   logic go;
   logic iss;

   assign acc = psel & penable;
   assign mapped = (paddr == `IRH_H_CTRL) || (paddr == `IRH_H_ARG) ||
      (paddr == `IRH_H_CNT) || (paddr == `IRH_H_WDATA) ||
      (paddr == `IRH_H_RDATA) || (paddr == `IRH_H_STATUS);
   assign go = acc & pwrite & (paddr == `IRH_H_CTRL) & pwdata[`IRH_GO_BIT] & ~s.busy;
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      n = s;
      n.op_v = 1'b0;
      iss = 1'b1;
      n.op_m = 1'b1;
      // Read data is latched in setup so it stands for the access phase
      if (psel && !penable) begin
         n.prdata = 32'h0;
         if (paddr == `IRH_H_STATUS) begin
            n.prdata = {29'h0, s.nack, s.wrdy, s.busy};
         end else if (paddr == `IRH_H_RDATA) begin
            n.prdata = {12'h000, s.rdata};
         end
      end
      if (acc && !pwrite && paddr == `IRH_H_RDATA) begin
         n.wrdy = 1'b0;
      end
      // Arguments are frozen while a frame runs
      if (acc && pwrite && !s.busy) begin
         if (paddr == `IRH_H_ARG) begin
            n.arg = pwdata[15:0];
         end else if (paddr == `IRH_H_CNT) begin
            n.cnt = pwdata[15:0];
         end else if (paddr == `IRH_H_WDATA) begin
            n.wdat = pwdata[19:0];
         end
      end
      case (s.st)
         H_IDLE: begin
            iss = 1'b0;
            n.busy = go;
            if (go) begin
               n.nack = 1'b0;
               n.cmd = irh_hcmd_t'(pwdata[1:0]);
               n.bc = 2'd0;
               n.sh = 20'h0;
               n.st = H_S1;
               case (irh_hcmd_t'(pwdata[1:0]))
                  HC_REG_RD: begin
                     n.cb = {`IRH_CODE_REG_RD, s.arg[7:0], 4'h0, 48'h0};
                     n.nb = 4'd2;
                     n.rcnt = 18'd4;
                  end
                  HC_REG_WR: begin
                     n.cb = {`IRH_CODE_REG_WR, s.arg[7:0], s.wdat, 32'h0};
                     n.nb = 4'd4;
                     n.rcnt = 18'd0;
                  end
                  HC_MEM_RD: begin
                     n.cb = {pwdata[`IRH_AREA_BIT] ? `IRH_CODE_MEM1 : `IRH_CODE_MEM0,
                        12'h000, s.cnt, s.arg, 16'h0};
                     n.nb = 4'd6; // Six command bytes; the low padding is never sent
                     n.rcnt = {s.cnt, 2'b00};
                  end
                  default: begin
                     n.nb = 4'd0;
                     n.rcnt = 18'd2;
                     n.st = H_S2;
                  end
               endcase
            end
         end
         H_S1: begin
            n.op_k = OP_START;
            n.ret = H_A1;
         end
         H_A1: begin
            n.op_k = OP_WRITE;
            n.op_b = `IRH_DEV_W;
            n.ret = H_SB;
         end
         H_SB: begin
            n.op_k = OP_WRITE;
            n.op_b = `IRH_SUB_WR;
            n.ret = H_CB;
         end
         H_CB: begin
            n.op_k = OP_WRITE;
            n.op_b = s.cb[63:56];
            n.cb = {s.cb[55:0], 8'h00};
            n.nb = s.nb - 4'd1;
            n.ret = (s.nb == 4'd1) ? H_P1 : H_CB;
         end
         H_P1: begin
            n.op_k = OP_STOP;
            n.ret = (s.cmd == HC_REG_WR) ? H_IDLE : H_S2;
         end
         H_S2: begin
            n.op_k = OP_START;
            n.ret = H_A2;
         end
         H_A2: begin
            n.op_k = OP_WRITE;
            n.op_b = `IRH_DEV_W;
            n.ret = H_SR;
         end
         H_SR: begin
            n.op_k = OP_WRITE;
            n.op_b = `IRH_SUB_RD;
            n.ret = H_RS;
         end
         H_RS: begin
            n.op_k = OP_START;
            n.ret = H_A3;
         end
         H_A3: begin
            n.op_k = OP_WRITE;
            n.op_b = `IRH_DEV_R;
            n.ret = (s.rcnt == 18'd0) ? H_P2 : H_RD;
         end
         H_RD: begin
            n.op_k = OP_READ;
            n.op_m = (s.rcnt != 18'd1);
            n.ret = H_RD;
         end
         H_HOLD: begin
            // Stall the link until software has taken the last word
            iss = 1'b0;
            if (!s.wrdy) begin
               n.st = H_RD;
            end
         end
         H_P2: begin
            n.op_k = OP_STOP;
            n.ret = H_IDLE;
         end
         default: begin
            iss = 1'b0;
            if (link.ans_valid) begin
               n.st = s.ret;
               if (s.op_k == OP_WRITE && !link.ans_ack) begin
                  n.nack = 1'b1;
                  n.st = H_P2;
               end else if (s.op_k == OP_READ) begin
                  n.rcnt = s.rcnt - 18'd1;
                  n.sh = {s.sh[11:0], link.ans_byte};
                  n.bc = s.bc + 2'd1;
                  if (s.bc == ((s.cmd == HC_DEF_RD) ? 2'd1 : 2'd3)) begin
                     n.bc = 2'd0;
                     n.rdata = {s.sh[11:0], link.ans_byte};
                     n.wrdy = 1'b1;
                     n.st = (s.rcnt == 18'd1) ? H_P2 : H_HOLD;
                  end else if (s.rcnt == 18'd1) begin
                     n.st = H_P2;
                  end
               end
            end
         end
      endcase
      if (iss) begin
         n.op_v = 1'b1;
         n.st = H_WAIT;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.st <= H_IDLE;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign link.op_valid = s.op_v;
   assign link.op_kind = s.op_k;
   assign link.op_byte = s.op_b;
   assign link.op_mack = s.op_m;
endmodule

//--- rtl/irh_link_if.sv
// Byte-level link between the controller and the device.
// Assumes both ends share pclk; no clock lives in here.
`timescale 1ns/1ps
interface irh_link_if import irh_pkg::*; ();
   logic op_valid;
   irh_op_t op_kind;
   logic [7:0] op_byte;
   logic op_mack;
   logic ans_valid;
   logic ans_ack;
   logic [7:0] ans_byte;
   modport dev (input op_valid, op_kind, op_byte, op_mack,
      output ans_valid, ans_ack, ans_byte);
   modport host (output op_valid, op_kind, op_byte, op_mack,
      input ans_valid, ans_ack, ans_byte);
endinterface

//--- rtl/irh_pkg.sv
// Types shared by both ends of the read command link.
// Assumes irh_consts.svh for widths.
package irh_pkg;
   typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} irh_op_t;
   typedef enum logic [1:0] {P_NONE, P_REG, P_MEM0, P_MEM1} irh_pend_t;
   typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_SUB, DS_CMD, DS_READ, DS_SKIP} irh_dst_t;
   typedef enum logic [1:0] {HC_REG_RD, HC_REG_WR, HC_MEM_RD, HC_DEF_RD} irh_hcmd_t;
   typedef enum logic [3:0] {H_IDLE, H_S1, H_A1, H_SB, H_CB, H_P1, H_S2, H_A2,
      H_SR, H_RS, H_A3, H_RD, H_HOLD, H_P2, H_WAIT} irh_hst_t;
   typedef struct packed {
      irh_dst_t st;
      logic [63:0] cb;
      logic [3:0] nb;
      irh_pend_t pend;
      logic [15:0] addr;
      logic [15:0] cnt;
      logic [1:0] bi;
      logic [19:0] setup;
      logic ans_v;
      logic ans_a;
      logic [7:0] ans_b;
   } irh_dev_s_t;
   typedef struct packed {
      irh_hst_t st;
      irh_hst_t ret;
      irh_hcmd_t cmd;
      logic [63:0] cb;
      logic [3:0] nb;
      logic [17:0] rcnt;
      logic [1:0] bc;
      logic [19:0] sh;
      logic [19:0] rdata;
      logic wrdy;
      logic busy;
      logic nack;
      logic [15:0] arg;
      logic [15:0] cnt;
      logic [19:0] wdat;
      logic [31:0] prdata;
      logic op_v;
      irh_op_t op_k;
      logic [7:0] op_b;
      logic op_m;
   } irh_host_s_t;
endpackage

//--- rtl/irh_word_ram.sv
// Word store with one synchronous write port and a combinational read.
// Assumes a single clock; contents are not reset.
`timescale 1ns/1ps
module irh_word_ram #(
   parameter int AW = 8
) (
   input wire logic pclk,
   input wire logic we,
   input wire logic [AW-1:0] wa,
   input wire logic [19:0] wd,
   input wire logic [AW-1:0] ra,
   output logic [19:0] rd
);
   logic [19:0] mem [0:(1<<AW)-1];

   // Write on the clock edge
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[wa] <= wd;
      end
   end

   // Read without latency so a byte can be answered in one cycle
   assign rd = mem[ra];
endmodule

//--- sim/irh_chk.sv
// Link checker between controller end and device end.
// Assumes both ends run on pclk; tb instantiates it beside the link.
`timescale 1ns/1ps
`include "irh_consts.svh"
module irh_chk import irh_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic op_valid,
   input wire irh_op_t op_kind,
   input wire logic [7:0] op_byte,
   input wire logic op_mack,
   input wire logic ans_valid,
   input wire logic ans_ack,
   input wire logic [7:0] ans_byte
);
   logic after_start;
   logic rd_nack;
   logic addr_op;

   // Last op was a start: the next byte must be a device address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         after_start <= 1'b0;
      end else if (op_valid) begin
         after_start <= (op_kind == OP_START);
      end
   end

   // Qualifiers for the frame rules
   assign rd_nack = op_valid && op_kind == OP_READ && !op_mack;
   assign addr_op = op_valid && after_start && op_kind == OP_WRITE;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------
   // Link rules
   // ----------------------------------------
   a_ans_one_later: assert property (op_valid |=> ans_valid)
      else $error("op not answered one cycle later");
   a_ans_has_cause: assert property (ans_valid |-> $past(op_valid))
      else $error("answer without an op");
   a_op_spaced: assert property (op_valid |=> !op_valid)
      else $error("ops closer than two cycles");
   a_nonread_zero: assert property (
      op_valid && op_kind != OP_READ |=> ans_byte == 8'h00)
      else $error("answer byte not zero");
   a_addr_acked: assert property (
      addr_op && (op_byte == `IRH_DEV_W || op_byte == `IRH_DEV_R) |=> ans_ack)
      else $error("device address not acked");
   a_start_addr: assert property (op_valid && after_start |-> op_kind == OP_WRITE)
      else $error("start not followed by address");
   a_nack_stop: assert property (
      rd_nack |=> !op_valid until (op_valid && op_kind == OP_STOP))
      else $error("last byte not followed by stop");
   a_nack_bound: assert property (rd_nack |-> ##[2:400] op_valid)
      else $error("no stop after last byte");
endmodule

//--- sim/tb.sv
// Bench: APB orders to the controller end, which drives the device end.
// Assumes irh_pkg and the design files compiled first.
`timescale 1ns/1ps
`include "irh_consts.svh"
module tb import irh_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, mem_we, mem_area, pslverr, pready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [10:0] mem_addr;
   logic [19:0] mem_wdata;
   logic [3:0] freq_step, volt_code;
   logic freq_range, read_pending, ev;
   int miscompares, total_checks, i, j;
   // Memory preload: {area, address, word}
   logic [31:0] tv [5] = '{32'h900f1234, 32'h9010abcd, 32'h90298765, 32'h1003c3c3,
      32'hfee5a5c3};

   irh_link_if lk ();
   irh_device_end u_irh_device_end (.link(lk), .pclk(pclk), .presetn(presetn),
      .mem_we(mem_we), .mem_area(mem_area), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .freq_step(freq_step), .freq_range(freq_range), .volt_code(volt_code),
      .read_pending(read_pending));
   irh_host_end u_irh_host_end (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(lk));
   irh_chk u_irh_chk (.pclk(pclk), .presetn(presetn), .op_valid(lk.op_valid),
      .op_kind(lk.op_kind), .op_byte(lk.op_byte), .op_mack(lk.op_mack),
      .ans_valid(lk.ans_valid), .ans_ack(lk.ans_ack), .ans_byte(lk.ans_byte));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer; waits for pready rather than assuming a latency
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Poll one status bit, bounded so a stuck controller cannot hang us
   task automatic wait_st(int b, logic v);
      for (i = 0; i < 300; i++) begin
         apb(1'b0, `IRH_H_STATUS, 32'h0);
         if (rv[b] === v) break;
      end
      chk("status bit", 32'(v), 32'(rv[b]));
   endtask

   task automatic word(logic [19:0] e);
      wait_st(1, 1'b1);
      apb(1'b0, `IRH_H_RDATA, 32'h0);
      chk("rdata", {12'h0, e}, rv);
   endtask

   task automatic final_report();
      if (miscompares == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Clock at 200 MHz
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Watchdog: the tests need a few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      final_report();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      mem_we = 1'b0;
      mem_area = 1'b0;
      mem_addr = 11'h0;
      mem_wdata = 20'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("freq_step", 32'h0, 32'(freq_step));
      chk("freq_range", 32'h0, 32'(freq_range));
      chk("volt_code", 32'h4, 32'(volt_code));
      chk("read_pending", 32'h0, 32'(read_pending));
      // Preload with strobe held high across words
      for (j = 0; j < 5; j++) begin
         mem_we <= 1'b1;
         mem_area <= tv[j][31];
         mem_addr <= tv[j][30:20];
         mem_wdata <= tv[j][19:0];
         @(posedge pclk);
      end
      mem_we <= 1'b0;
      // Program converter setup: step 6, upper range, voltage code b
      apb(1'b1, `IRH_H_ARG, 32'h8e);
      apb(1'b1, `IRH_H_WDATA, 32'h15b00);
      apb(1'b1, `IRH_H_CTRL, 32'h9);
      wait_st(0, 1'b0);
      chk("nack", 32'h0, 32'(rv[2]));
      chk("freq_step", 32'h6, 32'(freq_step));
      chk("freq_range", 32'h1, 32'(freq_range));
      chk("volt_code", 32'hb, 32'(volt_code));
      // Write-only register reads back as zero, upper bits clear
      apb(1'b1, `IRH_H_CTRL, 32'h8);
      word(20'h0);
      wait_st(0, 1'b0);
      // Three words from the second area, consecutive addresses
      apb(1'b1, `IRH_H_ARG, 32'h100);
      apb(1'b1, `IRH_H_CNT, 32'h3);
      apb(1'b1, `IRH_H_CTRL, 32'he);
      for (j = 0; j < 3; j++) begin
         word(tv[j][19:0]);
         if (j == 0) chk("read_pending", 32'h1, 32'(read_pending));
      end
      wait_st(0, 1'b0);
      // One word from the first area at the same address
      apb(1'b1, `IRH_H_CNT, 32'h1);
      apb(1'b1, `IRH_H_CTRL, 32'ha);
      word(tv[3][19:0]);
      wait_st(0, 1'b0);
      chk("read_pending", 32'h0, 32'(read_pending));
      // Default read: low sixteen bits of the status cell
      apb(1'b1, `IRH_H_CTRL, 32'hb);
      word(20'h0a5c3);
      wait_st(0, 1'b0);
      // Unmapped address is refused
      apb(1'b0, 8'h20, 32'h0);
      chk("pslverr", 32'h1, 32'(ev));
      chk("unmapped rdata", 32'h0, rv);
      final_report();
   end
endmodule
